//--- common/abnenc_regs.svh
`ifndef ABNENC_REGS_SVH
`define ABNENC_REGS_SVH
// Register indices; byte address is four times the index
`define ABNENC_IDX_ENC_CONFIG 8'h07
`define ABNENC_IDX_STEP_CONFIG 8'h0A
`define ABNENC_IDX_IN_CONFIG 8'h0C
`define ABNENC_IDX_EVENTS 8'h0E
`define ABNENC_IDX_STATUS 8'h0F
`define ABNENC_IDX_EXT_POS 8'h50
`define ABNENC_IDX_RELOAD 8'h51
`define ABNENC_IDX_RESOLUTION 8'h54
// Field positions
`define ABNENC_CFG_POL_A 0
`define ABNENC_CFG_POL_B 1
`define ABNENC_CFG_POL_N 2
`define ABNENC_CFG_AB_OFF 3
`define ABNENC_CFG_SENS_LO 4
`define ABNENC_CFG_SENS_HI 5
`define ABNENC_CFG_CONT 6
`define ABNENC_CFG_ONCE 7
`define ABNENC_CFG_CLR 8
`define ABNENC_CFG_WIDTH 9
`define ABNENC_STEP_MS_HI 3
`define ABNENC_STEP_FS_LO 4
`define ABNENC_STEP_FS_HI 15
`define ABNENC_RES_MANUAL 31
`define ABNENC_STATUS_N_BIT 15
`define ABNENC_EVENT_N_BIT 19
// Reset values
`define ABNENC_RST_CONFIG 9'h000
`define ABNENC_RST_STEP 16'h0C80
`define ABNENC_RST_RES 32'h0000_0000
// Fixed-point layout and timing counts
`define ABNENC_FRAC_BITS 16
`define ABNENC_DEC_BASE 17'h0_2710
`define ABNENC_DEC_MUL 14'h2710
`define ABNENC_DIV_STEPS 6'h30
`endif

//--- common/abnenc_pkg.sv
package abnenc_pkg;
  // Constant calculation sequencer
  typedef enum logic [1:0] {
    ABNENC_IDLE = 2'b00,
    ABNENC_DIV_INT = 2'b01,
    ABNENC_DIV_BIN = 2'b10,
    ABNENC_DIV_DEC = 2'b11
  } abnenc_fsm_t;

  // Avalon-MM slave request bundle
  typedef struct packed {
    logic [9:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } abnenc_req_t;

  // Whole module state
  typedef struct packed {
    logic [1:0] a_m;
    logic [1:0] b_m;
    logic [1:0] n_m;
    logic a_s;
    logic b_s;
    logic n_s;
    logic a_p;
    logic b_p;
    logic n_p;
    logic [8:0] cfg;
    logic in_dec;
    logic [15:0] step;
    logic [31:0] res;
    logic [31:0] reload;
    logic [31:0] pos;
    logic [15:0] frac;
    logic [14:0] c_int;
    logic [15:0] c_bin;
    logic [15:0] c_dec;
    logic forced;
    logic forced_dec;
    logic evt_n;
    logic stat_n;
    logic ack;
    logic [31:0] rdata;
    abnenc_fsm_t fsm;
    logic [5:0] cnt;
    logic [47:0] dvd;
    logic [31:0] rac;
    logic [30:0] savr;
  } abnenc_st_t;
endpackage

//--- rtl/abnenc_counter.sv
`timescale 1ns/100ps
`include "abnenc_regs.svh"

// Behaviour
// - Every single-channel A/B transition moves position by direction
// - Auto constant: microsteps times fullsteps over resolution
// - Constant is 15.16 fixed point step
// - Inexact binary fraction tries decimal 1/10000 units
// - Input config bit 0 picks fraction type unless auto constant is exact
// - Resolution bit 31 sets constant directly
// - Index active low unless polarity bit set
// - Sensitivity 00: condition follows active level
// - Sensitivity 01: fire on entering active
// - Sensitivity 10: fire on entering inactive
// - Sensitivity 11: fire on both edges
// - A/B qualifier levels default low, bit sets high
// - Qualifier-off bit ignores A/B levels
// - Continuous mode: status 15 and event 19
// - Event bit sticky until software clears
// - One-shot acts once then clears itself
// - Continuous clear reloads position each N event
// - One-shot clear reloads once, then clears bit
module abnenc_counter
  import abnenc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_n,
  output logic index_active
);

  // Byte-lane merge for partial writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
    logic [31:0] res_v;
    res_v = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res_v[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res_v;
  endfunction

  // Word index hit test, used by read and write decode
  function automatic logic hit(input logic [9:0] addr, input logic [7:0] idx);
    return addr[9:2] == idx;
  endfunction

  abnenc_st_t st_ff;       // Registered state
  abnenc_st_t nxt_st;      // Next state
  abnenc_req_t req;        // Bus request bundle
  logic wr_go;             // Write takes effect this edge
  logic ab_step;           // Single-channel quadrature change
  logic dir_up;            // Step direction
  logic n_act;             // Index at active level
  logic n_act_p;           // Index active one cycle earlier
  logic n_cond;            // Index condition by sensitivity
  logic ab_ok;             // A/B qualifier satisfied
  logic n_event;           // Qualified N event
  logic n_take;            // N event acted upon
  logic use_dec;           // Fraction in decimal units
  logic [15:0] c_frac;     // Active fraction of constant
  logic [14:0] c_whole;    // Active integer of constant
  logic [16:0] fsum;       // Fraction add/sub scratch
  logic carry;             // Fraction carry or borrow
  logic [31:0] rd_val;     // Read mux
  logic [31:0] rsh;        // Divider shifted remainder
  logic [8:0] msteps;      // Microsteps per fullstep
  logic [31:0] cur_const;  // Constant in 15.16 form

  assign req = '{avs_address, avs_read, avs_write, avs_writedata, avs_byteenable};

  // One wait state: request taken on the second edge after it rises
  assign avs_waitrequest = (req.read | req.write) & ~st_ff.ack;
  assign avs_readdata = st_ff.rdata;
  assign index_active = st_ff.stat_n;
  assign wr_go = req.write & st_ff.ack;
  assign msteps = 9'h100 >> st_ff.step[`ABNENC_STEP_MS_HI:0];

  // Quadrature decode and index qualification
  always_comb begin
    ab_step = (st_ff.a_s ^ st_ff.a_p) ^ (st_ff.b_s ^ st_ff.b_p);
    dir_up = st_ff.a_p ^ st_ff.b_s;
    n_act = ~(st_ff.n_s ^ st_ff.cfg[`ABNENC_CFG_POL_N]);
    n_act_p = ~(st_ff.n_p ^ st_ff.cfg[`ABNENC_CFG_POL_N]);
    case (st_ff.cfg[`ABNENC_CFG_SENS_HI:`ABNENC_CFG_SENS_LO])
      2'h0: n_cond = n_act;
      2'h1: n_cond = n_act & ~n_act_p;
      2'h2: n_cond = ~n_act & n_act_p;
      2'h3: n_cond = n_act ^ n_act_p;
      default: n_cond = 1'b0;
    endcase
    ab_ok = st_ff.cfg[`ABNENC_CFG_AB_OFF]
            | ((st_ff.a_s == st_ff.cfg[`ABNENC_CFG_POL_A])
               & (st_ff.b_s == st_ff.cfg[`ABNENC_CFG_POL_B]));
    n_event = n_cond & ab_ok;
    n_take = n_event & (st_ff.cfg[`ABNENC_CFG_CONT] | st_ff.cfg[`ABNENC_CFG_ONCE]);
  end

  // Select constant source and fraction type
  always_comb begin
    if (st_ff.res[`ABNENC_RES_MANUAL]) begin
      c_whole = st_ff.res[30:16];
      c_frac = st_ff.res[15:0];
      use_dec = st_ff.in_dec;
    end else begin
      c_whole = st_ff.c_int;
      use_dec = st_ff.forced ? st_ff.forced_dec : st_ff.in_dec;
      c_frac = use_dec ? st_ff.c_dec : st_ff.c_bin;
    end
    cur_const = {1'b0, c_whole, c_frac};
  end

  // Fractional accumulator step with binary or decimal wrap
  always_comb begin
    if (dir_up) begin
      fsum = {1'b0, st_ff.frac} + {1'b0, c_frac};
      carry = use_dec ? (fsum >= `ABNENC_DEC_BASE) : fsum[16];
      if (use_dec && carry) begin
        fsum = fsum - `ABNENC_DEC_BASE;
      end
    end else begin
      carry = st_ff.frac < c_frac;
      fsum = {1'b0, st_ff.frac} - {1'b0, c_frac};
      if (use_dec && carry) begin
        fsum = fsum + `ABNENC_DEC_BASE;
      end
    end
  end

  // Register read mux; unmapped and write-only read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    if (hit(req.address, `ABNENC_IDX_ENC_CONFIG)) begin
      rd_val = {23'h00_0000, st_ff.cfg};
    end else if (hit(req.address, `ABNENC_IDX_STEP_CONFIG)) begin
      rd_val = {16'h0000, st_ff.step};
    end else if (hit(req.address, `ABNENC_IDX_IN_CONFIG)) begin
      rd_val = {31'h0000_0000, st_ff.in_dec};
    end else if (hit(req.address, `ABNENC_IDX_EVENTS)) begin
      rd_val[`ABNENC_EVENT_N_BIT] = st_ff.evt_n;
    end else if (hit(req.address, `ABNENC_IDX_STATUS)) begin
      rd_val[`ABNENC_STATUS_N_BIT] = st_ff.stat_n;
    end else if (hit(req.address, `ABNENC_IDX_EXT_POS)) begin
      rd_val = st_ff.pos;
    end else if (hit(req.address, `ABNENC_IDX_RESOLUTION)) begin
      rd_val = cur_const;
    end
  end

  // Next-state logic
  always_comb begin
    nxt_st = st_ff;
    // Input synchronisers, then previous-sample stage
    nxt_st.a_m = {st_ff.a_m[0], enc_a};
    nxt_st.b_m = {st_ff.b_m[0], enc_b};
    nxt_st.n_m = {st_ff.n_m[0], enc_n};
    nxt_st.a_s = st_ff.a_m[1];
    nxt_st.b_s = st_ff.b_m[1];
    nxt_st.n_s = st_ff.n_m[1];
    nxt_st.a_p = st_ff.a_s;
    nxt_st.b_p = st_ff.b_s;
    nxt_st.n_p = st_ff.n_s;

    // Bus handshake
    nxt_st.ack = (req.read | req.write) & ~st_ff.ack;
    if (req.read & ~st_ff.ack) begin
      nxt_st.rdata = rd_val;
    end

    // Position counting by constant per transition
    if (ab_step) begin
      nxt_st.frac = fsum[15:0];
      if (dir_up) begin
        nxt_st.pos = st_ff.pos + {17'h0_0000, c_whole} + {31'h0000_0000, carry};
      end else begin
        nxt_st.pos = st_ff.pos - {17'h0_0000, c_whole} - {31'h0000_0000, carry};
      end
    end

    // N event actions
    nxt_st.stat_n = n_take;
    if (n_take) begin
      if (st_ff.cfg[`ABNENC_CFG_CLR]) begin
        nxt_st.pos = st_ff.reload;
        nxt_st.frac = 16'h0000;
      end
      if (~st_ff.cfg[`ABNENC_CFG_CONT]) begin
        nxt_st.cfg[`ABNENC_CFG_ONCE] = 1'b0;
      end
    end

    // Event flag: write one clears, a new event wins
    if (wr_go && hit(req.address, `ABNENC_IDX_EVENTS)
        && req.byteenable[2] && req.writedata[`ABNENC_EVENT_N_BIT]) begin
      nxt_st.evt_n = 1'b0;
    end
    if (n_take) begin
      nxt_st.evt_n = 1'b1;
    end

    // Register writes
    if (wr_go) begin
      if (hit(req.address, `ABNENC_IDX_ENC_CONFIG)) begin
        nxt_st.cfg = lane_merge({23'h00_0000, st_ff.cfg}, req.writedata,
                                req.byteenable)[8:0];
      end
      if (hit(req.address, `ABNENC_IDX_STEP_CONFIG)) begin
        nxt_st.step = lane_merge({16'h0000, st_ff.step}, req.writedata,
                                 req.byteenable)[15:0];
      end
      if (hit(req.address, `ABNENC_IDX_IN_CONFIG) && req.byteenable[0]) begin
        nxt_st.in_dec = req.writedata[0];
      end
      if (hit(req.address, `ABNENC_IDX_EXT_POS)) begin
        nxt_st.pos = lane_merge(st_ff.pos, req.writedata, req.byteenable);
        nxt_st.frac = 16'h0000;
      end
      if (hit(req.address, `ABNENC_IDX_RELOAD)) begin
        nxt_st.reload = lane_merge(st_ff.reload, req.writedata, req.byteenable);
      end
      if (hit(req.address, `ABNENC_IDX_RESOLUTION)) begin
        nxt_st.res = lane_merge(st_ff.res, req.writedata, req.byteenable);
      end
    end

    // Constant calculation: restoring divider shared by three passes
    rsh = {st_ff.rac[30:0], st_ff.dvd[47]};
    case (st_ff.fsm)
      ABNENC_IDLE: begin
        nxt_st.cnt = 6'h00;
      end
      ABNENC_DIV_INT, ABNENC_DIV_BIN, ABNENC_DIV_DEC: begin
        if (rsh >= {1'b0, st_ff.res[30:0]}) begin
          nxt_st.rac = rsh - {1'b0, st_ff.res[30:0]};
          nxt_st.dvd = {st_ff.dvd[46:0], 1'b1};
        end else begin
          nxt_st.rac = rsh;
          nxt_st.dvd = {st_ff.dvd[46:0], 1'b0};
        end
        nxt_st.cnt = st_ff.cnt + 6'h01;
        if (st_ff.cnt == `ABNENC_DIV_STEPS - 6'h01) begin
          nxt_st.cnt = 6'h00;
          // Remainder is still needed by the pass hand-over below
          case (st_ff.fsm)
            ABNENC_DIV_INT: begin
              nxt_st.c_int = nxt_st.dvd[14:0];
              nxt_st.savr = nxt_st.rac[30:0];
              nxt_st.dvd = {1'b0, nxt_st.rac[30:0], 16'h0000};
              nxt_st.fsm = ABNENC_DIV_BIN;
            end
            ABNENC_DIV_BIN: begin
              nxt_st.c_bin = nxt_st.dvd[15:0];
              nxt_st.forced = nxt_st.rac == 32'h0000_0000;
              nxt_st.forced_dec = 1'b0;
              nxt_st.dvd = 48'(st_ff.savr) * 48'(`ABNENC_DEC_MUL);
              nxt_st.fsm = ABNENC_DIV_DEC;
            end
            default: begin
              nxt_st.c_dec = nxt_st.dvd[15:0];
              if (!st_ff.forced && nxt_st.rac == 32'h0000_0000) begin
                nxt_st.forced = 1'b1;
                nxt_st.forced_dec = 1'b1;
              end
              nxt_st.fsm = ABNENC_IDLE;
            end
          endcase
          // Clear the remainder only after it has been handed over
          nxt_st.rac = 32'h0000_0000;
        end
      end
      default: begin
        nxt_st.fsm = ABNENC_IDLE;
      end
    endcase

    // A resolution write restarts calculation in automatic mode
    if (wr_go && hit(req.address, `ABNENC_IDX_RESOLUTION)
        && !nxt_st.res[`ABNENC_RES_MANUAL]) begin
      nxt_st.cnt = 6'h00;
      nxt_st.rac = 32'h0000_0000;
      if (nxt_st.res[30:0] == 31'h0000_0000) begin
        nxt_st.fsm = ABNENC_IDLE;
        nxt_st.c_int = 15'h0000;
        nxt_st.c_bin = 16'h0000;
        nxt_st.c_dec = 16'h0000;
        nxt_st.forced = 1'b0;
      end else begin
        nxt_st.fsm = ABNENC_DIV_INT;
        // Full-width product so 200 x 256 does not wrap
        nxt_st.dvd = 48'(st_ff.step[`ABNENC_STEP_FS_HI:`ABNENC_STEP_FS_LO])
                     * 48'(msteps);
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.cfg <= `ABNENC_RST_CONFIG;
      st_ff.step <= `ABNENC_RST_STEP;
      st_ff.res <= `ABNENC_RST_RES;
      st_ff.fsm <= ABNENC_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule

//--- tb/abnenc_counter_props.sv
`timescale 1ns/100ps
// Bus handshake and index-event checks at the top ports
module abnenc_counter_props (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_n,
  input wire logic index_active
);
  logic [8:0] cfg_ff; // Shadow of the index config register
  logic req; // Any bus request
  logic done; // Request taken at the coming edge
  assign req = avs_read | avs_write;
  assign done = req & ~avs_waitrequest;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Shadow follows bus writes and the one-shot self-clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= 9'h000;
    end else if (avs_write && done && avs_address[9:2] == 8'h07) begin
      cfg_ff <= avs_writedata[8:0];
    end else if (index_active && !cfg_ff[6]) begin
      cfg_ff[7] <= 1'b0;
    end
  end
  a_wait_first: assert property (req && !$past(req) |-> avs_waitrequest)
    else $error("waitrequest low on a fresh request");
  a_wait_once: assert property (avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
  a_idle_free: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest without a request");
  a_read_zero: assert property (avs_read && done && avs_address[9:2] inside {8'h00, 8'h51}
    |-> avs_readdata == 32'h0000_0000) else $error("hidden register read not zero");
  a_read_hold: assert property (avs_read && done |=> $stable(avs_readdata))
    else $error("read data moved after the transfer");
  a_event_mode: assert property (index_active |-> cfg_ff[6] || cfg_ff[7])
    else $error("index action with both modes off");
  a_once_single: assert property (index_active && !cfg_ff[6] |=> !index_active [*8])
    else $error("one-shot acted twice");
  a_edge_pulse: assert property (index_active && cfg_ff[5:4] != 2'b00 |=> !index_active)
    else $error("edge event longer than one cycle");
  a_rise_pol: assert property (index_active && cfg_ff[5:4] == 2'b01 |->
    $past(enc_n, 3) == cfg_ff[2] && $past(enc_n, 6) != cfg_ff[2])
    else $error("rising event without entry to active level");
  c_once: cover property (index_active && !cfg_ff[6]);
  c_level: cover property (index_active && cfg_ff[5:4] == 2'b00);
  c_hidden: cover property (avs_read && done && avs_address[9:2] == 8'h00);
endmodule

bind abnenc_counter abnenc_counter_props props_u (
  .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .enc_a(enc_a),
  .enc_b(enc_b), .enc_n(enc_n), .index_active(index_active));

//--- tb/abnenc_enc_model.sv
`timescale 1ns/100ps
// Quadrature encoder with index; gap sets how long each level stands
module abnenc_enc_model (
  input wire logic sys_clk,
  output logic enc_a,
  output logic enc_b,
  output logic enc_n
);
  logic [1:0] ph; // Gray phase, AB 00,01,11,10 counts up
  int gap; // Wait clocks after each A/B step; a level stands one clock more
  initial begin
    ph = 2'h0;
    enc_n = 1'b1;
    gap = 4;
  end
  assign enc_a = ph[1];
  assign enc_b = ph[1] ^ ph[0];
  // One channel changes per step, so no transition is skipped
  task automatic move(input logic up, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      ph <= up ? ph + 2'h1 : ph - 2'h1;
      repeat (gap) @(posedge sys_clk);
    end
  endtask
  // Park the index line at a level
  task automatic set_n(input logic lvl);
    @(posedge sys_clk);
    enc_n <= lvl;
    repeat (gap + 8) @(posedge sys_clk);
  endtask
  // Index at lvl for hold clocks, then back
  task automatic pulse(input logic lvl, input int hold);
    @(posedge sys_clk);
    enc_n <= lvl;
    repeat (hold) @(posedge sys_clk);
    enc_n <= ~lvl;
    repeat (gap + 8) @(posedge sys_clk);
  endtask
endmodule

//--- tb/abnenc_counter_tb.sv
`timescale 1ns/100ps
module abnenc_counter_tb
  import abnenc_pkg::*;
;
  logic sys_clk, rst_n, wreq, idx_act, enc_a, enc_b, enc_n;
  abnenc_req_t req; // Bus request bundle
  logic [31:0] rdata, got;
  int bad_count, cmp_count, n_seen;
  abnenc_counter dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(req.address), .avs_read(req.read),
    .avs_write(req.write), .avs_writedata(req.writedata), .avs_byteenable(req.byteenable),
    .avs_readdata(rdata), .avs_waitrequest(wreq), .enc_a(enc_a), .enc_b(enc_b),
    .enc_n(enc_n), .index_active(idx_act));
  abnenc_enc_model enc_u (.sys_clk(sys_clk), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Count cycles with index active
  always @(posedge sys_clk) if (idx_act === 1'b1) n_seen <= n_seen + 1;
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    req <= '{address: {idx, 2'b00}, read: ~wr, write: wr, writedata: wd, byteenable: 4'hF};
    // Look at waitrequest settled, before the edge it qualifies
    do begin
      @(negedge sys_clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) bad_count++;
    got = rdata;
    @(posedge sys_clk);
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    bus(1'b1, i, d);
  endtask
  task automatic rd_chk(input logic [7:0] i, input logic [31:0] e);
    bus(1'b0, i, 32'h0000_0000);
    check(got, e);
  endtask
  task automatic t_reset();
    rd_chk(8'h0A, 32'h0000_0C80);
    rd_chk(8'h07, 32'h0000_0000);
    rd_chk(8'h54, 32'h0000_0000);
    rd_chk(8'h51, 32'h0000_0000);
    rd_chk(8'h00, 32'h0000_0000);
    rd_chk(8'h0F, 32'h0000_0000);
  endtask
  // Auto constant 51200/1024 = 50, then 51200/256000 = 0.2 decimal
  task automatic t_const();
    wr(8'h54, 32'h0000_0400);
    repeat (150) @(posedge sys_clk);
    rd_chk(8'h54, 32'h0032_0000);
    wr(8'h50, 32'h0000_0000);
    enc_u.move(1'b1, 3);
    rd_chk(8'h50, 32'h0000_0096);
    enc_u.move(1'b0, 4);
    rd_chk(8'h50, 32'hFFFF_FFCE);
    wr(8'h54, 32'h0003_E800);
    repeat (150) @(posedge sys_clk);
    rd_chk(8'h54, 32'h0000_07D0);
    wr(8'h0C, 32'h0000_0001);
    wr(8'h54, 32'h8001_1388);
    rd_chk(8'h54, 32'h0001_1388);
    wr(8'h50, 32'h0000_0000);
    enc_u.move(1'b1, 2);
    rd_chk(8'h50, 32'h0000_0003);
    wr(8'h0C, 32'h0000_0000);
    wr(8'h54, 32'h8002_8000);
    enc_u.move(1'b1, 2);
    rd_chk(8'h50, 32'h0000_0008);
  endtask
  // Continuous reload, active high, A/B ignored while A is high
  task automatic t_cont();
    enc_u.set_n(1'b0);
    wr(8'h51, 32'h0000_1234);
    wr(8'h07, 32'h0000_015C);
    n_seen = 0;
    enc_u.pulse(1'b1, 6);
    check(n_seen, 1);
    rd_chk(8'h50, 32'h0000_1234);
    rd_chk(8'h0E, 32'h0008_0000);
    rd_chk(8'h0E, 32'h0008_0000);
    wr(8'h0E, 32'h0008_0000);
    rd_chk(8'h0E, 32'h0000_0000);
    wr(8'h50, 32'h0000_0000);
    enc_u.pulse(1'b1, 6);
    rd_chk(8'h50, 32'h0000_1234);
  endtask
  // Every sensitivity code with an active-low pulse of 5 clocks
  task automatic t_sens();
    logic [31:0] want [4];
    want = '{32'd5, 32'd1, 32'd1, 32'd2};
    wr(8'h07, 32'h0000_0000);
    enc_u.set_n(1'b1);
    for (int s = 0; s < 4; s++) begin
      wr(8'h07, 32'h0000_0048 | (s << 4));
      n_seen = 0;
      enc_u.pulse(1'b0, 5);
      check(n_seen, want[s]);
    end
  endtask
  // A/B levels qualify the event; slow encoder
  task automatic t_ab();
    enc_u.gap = 12;
    enc_u.move(1'b1, 1);
    wr(8'h07, 32'h0000_0050);
    n_seen = 0;
    enc_u.pulse(1'b0, 5);
    check(n_seen, 1);
    enc_u.move(1'b1, 1);
    enc_u.pulse(1'b0, 5);
    check(n_seen, 1);
    wr(8'h07, 32'h0000_0052);
    enc_u.pulse(1'b0, 5);
    check(n_seen, 2);
    enc_u.gap = 4;
  endtask
  // One-shot reload acts once and clears its own bit
  task automatic t_once();
    wr(8'h07, 32'h0000_0198);
    wr(8'h50, 32'h0000_0000);
    n_seen = 0;
    enc_u.pulse(1'b0, 5);
    rd_chk(8'h07, 32'h0000_0118);
    rd_chk(8'h50, 32'h0000_1234);
    wr(8'h50, 32'h0000_0000);
    enc_u.pulse(1'b0, 5);
    check(n_seen, 1);
    rd_chk(8'h50, 32'h0000_0000);
  endtask
  task automatic wrap_up();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Watchdog, well beyond the fewer than a thousand cycles expected
  initial begin
    #160000;
    bad_count++;
    wrap_up();
  end
  initial begin
    rst_n = 1'b0;
    req = '0;
    bad_count = 0;
    cmp_count = 0;
    n_seen = 0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_reset();
    t_const();
    t_cont();
    t_sens();
    t_ab();
    t_once();
    wrap_up();
  end
endmodule
